// ### design/serdes_ctrl_pkg.sv
// constants shared by the serdes reset and path select block
package serdes_ctrl_pkg;
    // three-level select pins arrive as two-bit level codes
    localparam logic [1:0] LEVEL_LOW  = 2'h0;
    localparam logic [1:0] LEVEL_MID  = 2'h1;
    localparam logic [1:0] LEVEL_HIGH = 2'h2;
    // pll rate range codes
    localparam logic [1:0] RANGE_195_400   = 2'h0;
    localparam logic [1:0] RANGE_400_800   = 2'h1;
    localparam logic [1:0] RANGE_800_1500  = 2'h2;
    // signal detect amplitude trip points, plain defaults
    localparam logic [7:0] SD_THRESH_LOW   = 8'h20;
    localparam logic [7:0] SD_THRESH_MID   = 8'h40;
    localparam logic [7:0] SD_THRESH_HIGH  = 8'h80;
    // settle time after device reset release, must stay below the limit
    localparam int         SETTLE_LIMIT    = 16;
    localparam logic [3:0] SETTLE_CYCLES   = 4'hA;
    // elasticity buffer pointers
    localparam int         EB_PTR_W        = 4;
    localparam logic [3:0] EB_NOMINAL_OFFSET = 4'h8;
    localparam logic [3:0] EB_READ_START   = 4'h0;
    // synchroniser width and bit positions of the pin bundle
    localparam int         SYNC_W          = 20;
    localparam int         P_DEV_RST       = 0;
    localparam int         P_LOOP          = 1;
    localparam int         P_SEL           = 2;
    localparam int         P_RATE          = 4;
    localparam int         P_HALF          = 6;
    localparam int         P_SD            = 7;
    localparam int         P_BOE           = 9;
    localparam int         P_OE_LE         = 13;
    localparam int         P_RX_LE         = 14;
    localparam int         P_BIST_LE       = 15;
    localparam int         P_PRI_IN        = 16;
    localparam int         P_SEC_IN        = 18;
    // reset values of the enable latches
    localparam logic [3:0] DRIVER_EN_RESET = 4'h0;
    localparam logic [1:0] RX_POWER_RESET  = 2'h0;
    localparam logic [3:0] BIST_EN_RESET   = 4'h0;
endpackage

// ### design/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // pins and filtered result
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        always_comb begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule
`default_nettype wire

// ### design/serdes_reset_and_path_select.sv
// rate decode, device reset, enable latches and receive path selection
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - rate select low/mid/high sets both plls to 195-400, 400-800, 800-1500 MBd
// - device reset low at clock edge initialises state, counters, buffer pointers
// - after reset release outputs become deterministic within under 16 cycles
// - device reset clears the bist, output enable and rx power latches
// - per channel, selector high picks primary input, low picks secondary
// - loopback feeds each channel's transmit data into its own receiver
// - loopback forces all serial drivers to one and ignores serial inputs
// - signal detect select picks one of three amplitude thresholds
// - device reset disables all serial output drivers until reloaded; loopback forces them to one, but only once the device is ready
// - device reset powers down both receive channels
module serdes_reset_and_path_select
    import serdes_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // static configuration pins
    input  wire logic [1:0] serial_rate_range_select,
    input  wire logic       half_rate_reference_clock_select,
    input  wire logic [1:0] signal_detect_level_select,
    input  wire logic       device_reset_n,
    // path control pins
    input  wire logic       all_port_loopback_enable,
    input  wire logic       rx_input_select_a,
    input  wire logic       rx_input_select_b,
    // enable latch pins
    input  wire logic [3:0] boe,
    input  wire logic       output_enable_latch_enable,
    input  wire logic       rx_power_latch_enable,
    input  wire logic       selftest_latch_enable,
    // serial inputs and transmit data
    input  wire logic       primary_serial_in_a,
    input  wire logic       primary_serial_in_b,
    input  wire logic       secondary_serial_in_a,
    input  wire logic       secondary_serial_in_b,
    input  wire logic [1:0] tx_serial,
    // configuration results
    output logic [1:0]      pll_rate_range,
    output logic            config_invalid,
    output logic [7:0]      sd_threshold,
    // enable latches
    output logic [3:0]      serial_driver_enable,
    output logic [1:0]      rx_channel_power,
    output logic [3:0]      bist_enable,
    // status
    output logic            device_ready,
    output logic [3:0]      eb_write_ptr,
    output logic [3:0]      eb_read_ptr,
    // data path
    output logic [1:0]      cdr_in,
    output logic            primary_serial_out_a,
    output logic            primary_serial_out_b,
    output logic            secondary_serial_out_a,
    output logic            secondary_serial_out_b
);
    typedef enum logic [1:0] {ST_RESET, ST_SETTLE, ST_RUN} dev_state_e;

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] pins_s;
    logic              dev_rst;
    logic              loop_s;
    logic [1:0]        sel_s;
    logic [1:0]        pri_s;
    logic [1:0]        sec_s;
    logic [1:0]        rate_s;
    logic [1:0]        sd_s;

    dev_state_e state;
    dev_state_e next_state;
    logic [3:0] settle_cnt;
    logic [3:0] next_settle_cnt;
    logic [1:0] next_pll_rate_range;
    logic       next_config_invalid;
    logic [7:0] next_sd_threshold;
    logic [3:0] next_serial_driver_enable;
    logic [1:0] next_rx_channel_power;
    logic [3:0] next_bist_enable;
    logic       next_device_ready;
    logic [3:0] next_eb_write_ptr;
    logic [3:0] next_eb_read_ptr;
    logic [1:0] next_cdr_in;
    logic [1:0] out_pri;
    logic [1:0] out_sec;
    logic [1:0] next_out_pri;
    logic [1:0] next_out_sec;

    assign pins = {secondary_serial_in_b, secondary_serial_in_a,
                   primary_serial_in_b, primary_serial_in_a,
                   selftest_latch_enable, rx_power_latch_enable,
                   output_enable_latch_enable, boe,
                   signal_detect_level_select, half_rate_reference_clock_select,
                   serial_rate_range_select, rx_input_select_b,
                   rx_input_select_a, all_port_loopback_enable, device_reset_n};

    // every pin but tx_serial crosses in; avoids metastable path switching
    pin_sync3 #(.W(SYNC_W)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (pins),
        .q       (pins_s)
    );

    // synchroniser resets to zero, so device reset reads active until pins settle
    assign dev_rst = !pins_s[P_DEV_RST];
    assign loop_s  = pins_s[P_LOOP];
    assign sel_s   = pins_s[P_SEL +: 2];
    assign rate_s  = pins_s[P_RATE +: 2];
    assign sd_s    = pins_s[P_SD +: 2];
    assign pri_s   = pins_s[P_PRI_IN +: 2];
    assign sec_s   = pins_s[P_SEC_IN +: 2];

    always_comb begin
        // rate decode; unused level code falls back to mid
        case (rate_s)
            LEVEL_LOW:  next_pll_rate_range = RANGE_195_400;
            LEVEL_HIGH: next_pll_rate_range = RANGE_800_1500;
            default:    next_pll_rate_range = RANGE_400_800;
        endcase
        // flagged only; the host owns this combination
        next_config_invalid = (rate_s == LEVEL_LOW) && pins_s[P_HALF];
        case (sd_s)
            LEVEL_LOW:  next_sd_threshold = SD_THRESH_LOW;
            LEVEL_HIGH: next_sd_threshold = SD_THRESH_HIGH;
            default:    next_sd_threshold = SD_THRESH_MID;
        endcase
    end

    always_comb begin
        next_state                = state;
        next_settle_cnt           = settle_cnt;
        next_serial_driver_enable = serial_driver_enable;
        next_rx_channel_power     = rx_channel_power;
        next_bist_enable          = bist_enable;
        next_eb_write_ptr         = eb_write_ptr + 4'h1;
        next_eb_read_ptr          = eb_read_ptr + 4'h1;
        if (dev_rst) begin
            next_state                = ST_RESET;
            next_settle_cnt           = 4'h0;
            next_eb_write_ptr         = EB_NOMINAL_OFFSET;
            next_eb_read_ptr          = EB_READ_START;
            next_serial_driver_enable = DRIVER_EN_RESET;
            next_rx_channel_power     = RX_POWER_RESET;
            next_bist_enable          = BIST_EN_RESET;
        end else begin
            // latches follow boe while their enable is high, hold when low
            if (pins_s[P_OE_LE])
                next_serial_driver_enable = pins_s[P_BOE +: 4];
            if (pins_s[P_RX_LE])
                next_rx_channel_power = pins_s[P_BOE +: 2];
            // boe low selects bist, so the enable is inverted
            if (pins_s[P_BIST_LE])
                next_bist_enable = ~pins_s[P_BOE +: 4];
            case (state)
                ST_RESET: begin
                    next_state = ST_SETTLE;
                end
                ST_SETTLE: begin
                    next_settle_cnt = settle_cnt + 4'h1;
                    if (settle_cnt == SETTLE_CYCLES)
                        next_state = ST_RUN;
                end
                ST_RUN: begin
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_RESET;
                end
            endcase
        end
        next_device_ready = (next_state == ST_RUN);
    end

    // per-channel receive selection and driver levels
    genvar ch;
    for (ch = 0; ch < 2; ch++) begin : g_chan
        always_comb begin
            next_cdr_in[ch]  = 1'b0;
            next_out_pri[ch] = 1'b0;
            next_out_sec[ch] = 1'b0;
            if (next_device_ready) begin
                if (loop_s) begin
                    next_cdr_in[ch]  = tx_serial[ch];
                    next_out_pri[ch] = 1'b1;
                    next_out_sec[ch] = 1'b1;
                end else begin
                    next_cdr_in[ch]  = sel_s[ch] ? pri_s[ch] : sec_s[ch];
                    next_out_pri[ch] = tx_serial[ch] & next_serial_driver_enable[2*ch];
                    next_out_sec[ch] = tx_serial[ch] & next_serial_driver_enable[2*ch+1];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state                <= ST_RESET;
            settle_cnt           <= 4'h0;
            pll_rate_range       <= RANGE_195_400;
            config_invalid       <= 1'b0;
            sd_threshold         <= SD_THRESH_LOW;
            serial_driver_enable <= DRIVER_EN_RESET;
            rx_channel_power     <= RX_POWER_RESET;
            bist_enable          <= BIST_EN_RESET;
            device_ready         <= 1'b0;
            eb_write_ptr         <= EB_NOMINAL_OFFSET;
            eb_read_ptr          <= EB_READ_START;
            cdr_in               <= 2'h0;
            out_pri              <= 2'h0;
            out_sec              <= 2'h0;
        end else begin
            state                <= next_state;
            settle_cnt           <= next_settle_cnt;
            pll_rate_range       <= next_pll_rate_range;
            config_invalid       <= next_config_invalid;
            sd_threshold         <= next_sd_threshold;
            serial_driver_enable <= next_serial_driver_enable;
            rx_channel_power     <= next_rx_channel_power;
            bist_enable          <= next_bist_enable;
            device_ready         <= next_device_ready;
            eb_write_ptr         <= next_eb_write_ptr;
            eb_read_ptr          <= next_eb_read_ptr;
            cdr_in               <= next_cdr_in;
            out_pri              <= next_out_pri;
            out_sec              <= next_out_sec;
        end
    end

    assign primary_serial_out_a   = out_pri[0];
    assign primary_serial_out_b   = out_pri[1];
    assign secondary_serial_out_a = out_sec[0];
    assign secondary_serial_out_b = out_sec[1];

    // checks
    property p_rate_low;
        @(posedge clk) disable iff (!reset_n)
        (rate_s == LEVEL_LOW) |=> (pll_rate_range == RANGE_195_400);
    endproperty
    a_rate_low: assert property (p_rate_low) else $error("rate low not decoded");

    property p_invalid;
        @(posedge clk) disable iff (!reset_n)
        (rate_s == LEVEL_LOW && pins_s[P_HALF]) |=> config_invalid;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid config not flagged");

    property p_reset_init;
        @(posedge clk) disable iff (!reset_n)
        dev_rst |=> (state == ST_RESET && eb_write_ptr == EB_NOMINAL_OFFSET
                     && eb_read_ptr == EB_READ_START && !device_ready);
    endproperty
    a_reset_init: assert property (p_reset_init) else $error("reset init wrong");

    property p_settle;
        @(posedge clk) disable iff (!reset_n)
        (!dev_rst && $past(dev_rst)) ##1 (!dev_rst) [*8] |-> ##[1:6] device_ready;
    endproperty
    a_settle: assert property (p_settle) else $error("outputs not settled in time");

    property p_bist_clear;
        @(posedge clk) disable iff (!reset_n)
        dev_rst |=> (bist_enable == BIST_EN_RESET);
    endproperty
    a_bist_clear: assert property (p_bist_clear) else $error("bist latch not cleared");

    property p_oe_clear;
        @(posedge clk) disable iff (!reset_n)
        dev_rst |=> (serial_driver_enable == DRIVER_EN_RESET && out_pri == 2'h0
                     && out_sec == 2'h0);
    endproperty
    a_oe_clear: assert property (p_oe_clear) else $error("drivers not disabled");

    property p_rx_clear;
        @(posedge clk) disable iff (!reset_n)
        dev_rst |=> (rx_channel_power == RX_POWER_RESET);
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx power not cleared");

    property p_select;
        @(posedge clk) disable iff (!reset_n)
        (next_device_ready && !loop_s)
            |=> (cdr_in[0] == ($past(sel_s[0]) ? $past(pri_s[0]) : $past(sec_s[0])));
    endproperty
    a_select: assert property (p_select) else $error("wrong input selected");

    property p_loop_route;
        @(posedge clk) disable iff (!reset_n)
        (next_device_ready && loop_s) |=> (cdr_in == $past(tx_serial));
    endproperty
    a_loop_route: assert property (p_loop_route) else $error("loopback not routed");

    property p_loop_force;
        @(posedge clk) disable iff (!reset_n)
        (next_device_ready && loop_s) |=> (out_pri == 2'h3 && out_sec == 2'h3);
    endproperty
    a_loop_force: assert property (p_loop_force) else $error("drivers not forced high");

    property p_sd_mid;
        @(posedge clk) disable iff (!reset_n)
        (sd_s == LEVEL_MID) |=> (sd_threshold == SD_THRESH_MID);
    endproperty
    a_sd_mid: assert property (p_sd_mid) else $error("sd threshold wrong");

    c_ready: cover property (@(posedge clk) disable iff (!reset_n) $rose(device_ready));
    c_loop: cover property (@(posedge clk) disable iff (!reset_n) device_ready && loop_s);
    c_invalid: cover property (@(posedge clk) disable iff (!reset_n) config_invalid);
    c_secondary: cover property (@(posedge clk) disable iff (!reset_n)
        device_ready && !loop_s && !sel_s[1]);
endmodule
`default_nettype wire

// ### verif/host_pin_model.sv
// host model driving the rate range, half-rate clock select and device reset pins
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // requests from the bench
    input  wire logic [1:0] want_rate,
    input  wire logic       want_half,
    input  wire logic       want_dev_rst_n,
    input  wire logic       allow_bad,
    // pins toward the device
    output logic [1:0]      serial_rate_range_select,
    output logic            half_rate_reference_clock_select,
    output logic            device_reset_n
);
    logic [3:0] boot_cnt;

    // pins move on the falling edge, well away from the sampling edge
    always @(negedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // one writer per pin; the device ignores the pins while reset_n is low
            boot_cnt                 <= 4'h0;
            device_reset_n           <= 1'b0;
            serial_rate_range_select <= 2'h2;
            half_rate_reference_clock_select  <= 1'b0;
        end else begin
            serial_rate_range_select <= want_rate;
            // half-rate clock refused at low rate unless a test breaks it on purpose
            half_rate_reference_clock_select <= want_half & ((want_rate != 2'h0) | allow_bad);
            // device reset held after power-up so buffer pointers start clean
            if (boot_cnt != 4'hF) begin
                boot_cnt       <= boot_cnt + 4'h1;
                device_reset_n <= 1'b0;
            end else begin
                device_reset_n <= want_dev_rst_n;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/serdes_reset_and_path_select_tb.sv
// self-checking bench for the reset and path select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module serdes_reset_and_path_select_tb
    import serdes_ctrl_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, want_half = 1'b0, want_dev_rst_n = 1'b1;
    logic allow_bad = 1'b0, half_rate_reference_clock_select, device_reset_n;
    logic [1:0] want_rate = 2'h2, serial_rate_range_select, signal_detect_level_select = 2'h0;
    logic all_port_loopback_enable = 1'b0, rx_input_select_a = 1'b1, rx_input_select_b = 1'b1;
    logic [3:0] boe = 4'h0;
    logic oe_le = 1'b0, rx_le = 1'b0, bist_le = 1'b0;
    logic primary_serial_in_a = 1'b0, primary_serial_in_b = 1'b0;
    logic secondary_serial_in_a = 1'b0, secondary_serial_in_b = 1'b0;
    logic [1:0] tx_serial = 2'h0, pll_rate_range, rx_channel_power, cdr_in;
    logic config_invalid, device_ready;
    logic primary_serial_out_a, primary_serial_out_b, secondary_serial_out_a, secondary_serial_out_b;
    logic [7:0] sd_threshold;
    logic [3:0] serial_driver_enable, bist_enable, eb_write_ptr, eb_read_ptr;
    wire  [3:0] outs = {secondary_serial_out_b, primary_serial_out_b,
                        secondary_serial_out_a, primary_serial_out_a};
    int n_mismatch = 0, total_checks = 0, cyc_cnt = 0;
    logic [31:0] seed = 32'h15;

    host_pin_model host_u (.clk, .reset_n, .want_rate, .want_half, .want_dev_rst_n,
        .allow_bad, .serial_rate_range_select, .half_rate_reference_clock_select, .device_reset_n);

    serdes_reset_and_path_select dut_u (.clk, .reset_n, .serial_rate_range_select,
        .half_rate_reference_clock_select, .signal_detect_level_select, .device_reset_n,
        .all_port_loopback_enable, .rx_input_select_a, .rx_input_select_b, .boe,
        .output_enable_latch_enable(oe_le), .rx_power_latch_enable(rx_le),
        .selftest_latch_enable(bist_le), .primary_serial_in_a, .primary_serial_in_b,
        .secondary_serial_in_a, .secondary_serial_in_b, .tx_serial, .pll_rate_range,
        .config_invalid, .sd_threshold, .serial_driver_enable, .rx_channel_power,
        .bist_enable, .device_ready, .eb_write_ptr, .eb_read_ptr, .cdr_in,
        .primary_serial_out_a, .primary_serial_out_b, .secondary_serial_out_a,
        .secondary_serial_out_b);

    always #4 clk = ~clk;

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [1:0] exp_rate(input logic [1:0] c);
        return (c == LEVEL_LOW) ? RANGE_195_400 : (c == LEVEL_HIGH) ? RANGE_800_1500 : RANGE_400_800;
    endfunction

    function automatic logic [7:0] exp_sd(input logic [1:0] c);
        return (c == 2'h0) ? SD_THRESH_LOW : (c == 2'h2) ? SD_THRESH_HIGH : SD_THRESH_MID;
    endfunction

    // order {sec_b, pri_b, sec_a, pri_a}
    function automatic logic [3:0] exp_out(input logic [1:0] t, input logic [3:0] e);
        return {t[1] & e[3], t[1] & e[2], t[0] & e[1], t[0] & e[0]};
    endfunction

    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task load(input logic [3:0] b);
        boe = b; oe_le = 1'b1; rx_le = 1'b1; bist_le = 1'b1;
        cyc(6);
        oe_le = 1'b0; rx_le = 1'b0; bist_le = 1'b0;
        cyc(6);
    endtask

    // bounded wait, pins need four edges through the synchroniser
    task wait_ready(input int lim, output int n);
        n = 0;
        while (device_ready !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // run takes a few hundred cycles, ceiling leaves ample margin
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt >= 4000) begin
            n_mismatch++;
            $display("Error timeout expected done seen hang");
            summarize();
        end
    end

    initial begin
        int n;
        logic [31:0] v;
        logic [1:0] prev;
        cyc(12);
        reset_n = 1'b1;
        wait_ready(60, n);
        `CHK("boot_ready", 1'b1, device_ready)
        for (int i = 0; i < 4; i++) begin
            want_rate = i[1:0]; signal_detect_level_select = i[1:0]; want_half = 1'b1;
            cyc(7);
            `CHK("pll_rate_range", exp_rate(i[1:0]), pll_rate_range)
            `CHK("sd_threshold", exp_sd(i[1:0]), sd_threshold)
            `CHK("config_invalid", 1'b0, config_invalid)
        end
        allow_bad = 1'b1; want_rate = 2'h0;
        cyc(7);
        `CHK("config_invalid_bad", 1'b1, config_invalid)
        allow_bad = 1'b0; want_half = 1'b0; want_rate = 2'h2;
        $display("test codes done");
        for (int k = 0; k < 6; k++) begin
            v = rnd();
            load(v[3:0]);
            boe = ~v[3:0]; tx_serial = v[5:4];
            cyc(6);
            `CHK("driver_en_hold", v[3:0], serial_driver_enable)
            `CHK("rx_power_hold", v[1:0], rx_channel_power)
            `CHK("bist_hold", ~v[3:0], bist_enable)
            `CHK("serial_outs", exp_out(v[5:4], v[3:0]), outs)
        end
        $display("test latches done");
        load(4'hA);
        want_dev_rst_n = 1'b0;
        cyc(7);
        `CHK("rst_driver_en", 4'h0, serial_driver_enable)
        `CHK("rst_rx_power", 2'h0, rx_channel_power)
        `CHK("rst_bist", 4'h0, bist_enable)
        `CHK("rst_wr_ptr", 4'h8, eb_write_ptr)
        `CHK("rst_rd_ptr", 4'h0, eb_read_ptr)
        `CHK("rst_ready", 1'b0, device_ready)
        boe = 4'hF; oe_le = 1'b1;
        cyc(6);
        `CHK("rst_le_ignored", 4'h0, serial_driver_enable)
        oe_le = 1'b0;
        cyc(1);
        want_dev_rst_n = 1'b1;
        wait_ready(40, n);
        `CHK("rel_ready", 1'b1, device_ready)
        // host lag 0-1, sync 4, then under 16 from the first sampling flop
        `CHK("rel_settle", 1'b1, n <= 17)
        `CHK("rel_driver_en", 4'h0, serial_driver_enable)
        `CHK("rel_rx_power", 2'h0, rx_channel_power)
        $display("test device reset done");
        for (int k = 0; k < 4; k++) begin
            v = rnd();
            primary_serial_in_a = v[0]; secondary_serial_in_a = ~v[0];
            primary_serial_in_b = v[1]; secondary_serial_in_b = ~v[1];
            rx_input_select_a = k[0]; rx_input_select_b = k[1];
            cyc(7);
            prev = {k[1] ? v[1] : ~v[1], k[0] ? v[0] : ~v[0]};
            `CHK("cdr_select", prev, cdr_in)
            rx_input_select_a = ~k[0]; rx_input_select_b = ~k[1];
            cyc(2);
            `CHK("cdr_sync_hold", prev, cdr_in)
            cyc(5);
            `CHK("cdr_select_flip", ~prev, cdr_in)
        end
        $display("test input select done");
        load(4'hF);
        all_port_loopback_enable = 1'b1;
        for (int k = 0; k < 3; k++) begin
            v = rnd();
            tx_serial = v[1:0];
            primary_serial_in_a = ~v[0]; secondary_serial_in_a = ~v[0];
            primary_serial_in_b = ~v[1]; secondary_serial_in_b = ~v[1];
            cyc(6);
            `CHK("loop_cdr", v[1:0], cdr_in)
            `CHK("loop_outs", 4'hF, outs)
        end
        all_port_loopback_enable = 1'b0;
        cyc(7);
        `CHK("unloop_outs", exp_out(tx_serial, 4'hF), outs)
        $display("test loopback done");
        summarize();
    end
endmodule
`default_nettype wire
